// ### hdl/lcm_curtain_muting_block.sv
`timescale 1ns/1ps
`include "lcm_regs.svh"
module lcm_curtain_muting_block #(
  parameter int TICK_CYC = `LCM_TICK_CYC,
  parameter int W = `LCM_WIN_W
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // register port
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // safety input terminals
  input wire lcm_pkg::lcm_in_t pins_i,
  // contacts
  output lcm_pkg::lcm_out_t contacts_o
);
  import lcm_pkg::*;

  // ==========================================
  // register offsets
  localparam logic [3:0] OFS_MODE = 4'h0;
  localparam logic [3:0] OFS_MISMATCH = 4'h1;
  localparam logic [3:0] OFS_MUTING = 4'h2;
  localparam logic [3:0] OFS_SYNC = 4'h3;
  localparam logic [3:0] OFS_RELEASE = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h5;

  typedef struct packed {
    lcm_in_t sync1;
    lcm_in_t sync2;
    lcm_in_t prev;
    lcm_cfg_t cfg;
    lcm_state_t state;
    logic proof_done;
    logic ovr_active;
    logic [31:0] rdata;
    lcm_out_t outs;
  } lcm_st_t;

  lcm_st_t s_reg;
  lcm_st_t s_next;
  logic tick;
  logic mis_run, mis_exp, mut_run, mut_exp, syn_run, syn_exp, rel_run, rel_exp;
  logic [W-1:0] mis_el, mut_el, syn_el, rel_el;

  // ==========================================
  // time base and supervision windows
  lcm_tick #(.TICK_CYC(TICK_CYC)) u_tick (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .tick_o(tick)
  );
  lcm_win #(.W(W)) u_mis (
    .clk_i(clk_i), .nrst_i(nrst_i), .tick_i(tick), .run_i(mis_run),
    .limit_i(s_reg.cfg.mismatch_win), .expired_o(mis_exp), .elapsed_o(mis_el)
  );
  lcm_win #(.W(W)) u_mut (
    .clk_i(clk_i), .nrst_i(nrst_i), .tick_i(tick), .run_i(mut_run),
    .limit_i(s_reg.cfg.muting_win), .expired_o(mut_exp), .elapsed_o(mut_el)
  );
  lcm_win #(.W(W)) u_syn (
    .clk_i(clk_i), .nrst_i(nrst_i), .tick_i(tick), .run_i(syn_run),
    .limit_i(s_reg.cfg.sync_win), .expired_o(syn_exp), .elapsed_o(syn_el)
  );
  lcm_win #(.W(W)) u_rel (
    .clk_i(clk_i), .nrst_i(nrst_i), .tick_i(tick), .run_i(rel_run),
    .limit_i(s_reg.cfg.release_win), .expired_o(rel_exp), .elapsed_o(rel_el)
  );

  // ==========================================
  // input views on the synchronised pins
  lcm_in_t p;
  logic ch1, ch2, clear, one_ch, active;
  logic grp_a_on, grp_a_mis, grp_b_on, grp_b_mis, ack_fall, sens_req, sens_end;
  assign p = s_reg.sync2;
  assign ch1 = p.curtain_channel_one;
  assign ch2 = p.curtain_channel_two;
  assign clear = ch1 && ch2;
  assign one_ch = ch1 ^ ch2;
  assign active = (s_reg.cfg.gate_ext == `LCM_GATE_NONE) || p.gate_coil;
  assign grp_a_on = p.first_group_sensor_one && p.first_group_sensor_two;
  assign grp_a_mis = p.first_group_sensor_one ^ p.first_group_sensor_two;
  assign grp_b_on = p.second_group_sensor_one && p.second_group_sensor_two;
  assign grp_b_mis = p.second_group_sensor_one ^ p.second_group_sensor_two;
  assign ack_fall = s_reg.prev.operator_acknowledge_coil && !p.operator_acknowledge_coil;

  // four-sensor setups may start muting on either group; two-sensor setups use group A only
  function automatic logic four_sensor(input logic [1:0] arr);
    four_sensor = (arr == `LCM_ARR_4P) || (arr == `LCM_ARR_4S);
  endfunction
  assign sens_req = grp_a_on || (four_sensor(s_reg.cfg.arrangement) && grp_b_on);
  assign sens_end = !grp_a_on && !(four_sensor(s_reg.cfg.arrangement) && grp_b_on);

  // ==========================================
  // window run conditions
  assign mis_run = active && one_ch;
  assign syn_run = active && (grp_a_mis ||
                   (four_sensor(s_reg.cfg.arrangement) && grp_b_mis));
  assign mut_run = s_reg.state == ST_MUTING;
  assign rel_run = s_reg.ovr_active;

  always_comb
  begin
    s_next = s_reg;
    s_next.sync1 = pins_i;
    s_next.sync2 = s_reg.sync1;
    s_next.prev = p;
    s_next.rdata = 32'h0000_0000;

    // ---- register writes
    if (wr_i)
    begin
      case (addr_i)
        OFS_MODE:
        begin
          s_next.cfg.gate_ext = wdata_i[0];
          s_next.cfg.restart = (wdata_i[2:1] == 2'h3) ? `LCM_RST_MANUAL : wdata_i[2:1];
          s_next.cfg.startup_proof = wdata_i[3];
          s_next.cfg.arrangement = wdata_i[5:4];
        end
        OFS_MISMATCH: s_next.cfg.mismatch_win = wdata_i[W-1:0];
        OFS_MUTING: s_next.cfg.muting_win = wdata_i[W-1:0];
        OFS_SYNC: s_next.cfg.sync_win = wdata_i[W-1:0];
        OFS_RELEASE: s_next.cfg.release_win = wdata_i[W-1:0];
        default:
        begin
        end
      endcase
    end

    // ---- register reads, answered one cycle later
    if (rd_i)
    begin
      case (addr_i)
        OFS_MODE: s_next.rdata = {26'h0, s_reg.cfg.arrangement, s_reg.cfg.startup_proof,
                                  s_reg.cfg.restart, s_reg.cfg.gate_ext};
        OFS_MISMATCH: s_next.rdata = {3'h0, mis_el, 3'h0, s_reg.cfg.mismatch_win};
        OFS_MUTING: s_next.rdata = {3'h0, mut_el, 3'h0, s_reg.cfg.muting_win};
        OFS_SYNC: s_next.rdata = {3'h0, syn_el, 3'h0, s_reg.cfg.sync_win};
        OFS_RELEASE: s_next.rdata = {3'h0, rel_el, 3'h0, s_reg.cfg.release_win};
        OFS_STATUS: s_next.rdata = {21'h0_0000, s_reg.proof_done, s_reg.ovr_active,
                                    s_reg.state, s_reg.outs};
        default: s_next.rdata = 32'h0000_0000;
      endcase
    end

    // ---- sequence
    if (s_reg.ovr_active && (rel_exp || !p.override_coil || !active))
      s_next.ovr_active = 1'b0;
    case (s_reg.state)
      ST_IDLE:
      begin
        if (active)
        begin
          if (s_reg.cfg.startup_proof && !s_reg.proof_done)
            s_next.state = ST_PROOF;
          else if (clear)
            s_next.state = (s_reg.cfg.restart == `LCM_RST_AUTO) ? ST_ENABLED : ST_WAIT_ACK;
        end
      end
      ST_PROOF:
      begin
        // proof needs an interruption seen, then an acknowledge with the area clear
        if (!active)
          s_next.state = ST_IDLE;
        else if (!ch1 && !ch2)
          s_next.proof_done = 1'b1;
        else if (s_reg.proof_done && clear && ack_fall)
          s_next.state = ST_ENABLED;
      end
      ST_WAIT_ACK:
      begin
        // supervised restart accepts the acknowledge only on its falling edge
        if (!active || !clear)
          s_next.state = ST_IDLE;
        else if (s_reg.cfg.restart == `LCM_RST_SUPV ? ack_fall : p.operator_acknowledge_coil)
          s_next.state = ST_ENABLED;
      end
      ST_ENABLED:
      begin
        if (!active)
          s_next.state = ST_IDLE;
        else if (sens_req && !syn_run)
          s_next.state = ST_MUTING;
        else if (!clear)
          s_next.state = ST_IDLE;
      end
      ST_MUTING:
      begin
        if (!active)
          s_next.state = ST_IDLE;
        else if (sens_end && !syn_run)
          s_next.state = clear ? ST_ENABLED : ST_FAULT;
      end
      ST_FAULT:
      begin
        // an override may bridge the curtain for the release window, then a curtain broken on both channels
        if (p.override_coil && !s_reg.prev.override_coil && s_reg.cfg.release_win != '0)
          s_next.ovr_active = 1'b1;
        if (!ch1 && !ch2 && !s_reg.ovr_active)
          s_next.state = ST_IDLE;
      end
      default: s_next.state = ST_IDLE;
    endcase
    if (active && (mis_exp || syn_exp || (mut_exp && s_reg.state == ST_MUTING)))
      s_next.state = ST_FAULT;

    // ---- contacts
    s_next.outs.safe_enable_contact = (s_next.state == ST_ENABLED) ||
                                      (s_next.state == ST_MUTING);
    s_next.outs.muting_active_contact = (s_next.state == ST_MUTING) || s_next.ovr_active;
    s_next.outs.fault_contact = s_next.state == ST_FAULT;
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      s_reg <= '0;
      s_reg.state <= ST_IDLE;
      s_reg.cfg.gate_ext <= `LCM_GATE_NONE;
      s_reg.cfg.restart <= `LCM_RST_MANUAL;
      s_reg.cfg.startup_proof <= 1'b0;
      s_reg.cfg.arrangement <= `LCM_ARR_2P;
      s_reg.cfg.mismatch_win <= `LCM_MISMATCH_RST;
      s_reg.cfg.muting_win <= `LCM_MUTING_RST;
      s_reg.cfg.sync_win <= `LCM_SYNC_RST;
      s_reg.cfg.release_win <= `LCM_RELEASE_RST;
    end
    else
      s_reg <= s_next;
  end

  assign rdata_o = s_reg.rdata;
  assign contacts_o = s_reg.outs;
endmodule

// ### hdl/lcm_pkg.sv
package lcm_pkg;
  typedef struct packed {
    logic gate_ext;
    logic [1:0] restart;
    logic startup_proof;
    logic [1:0] arrangement;
    logic [12:0] mismatch_win;
    logic [12:0] muting_win;
    logic [12:0] sync_win;
    logic [12:0] release_win;
  } lcm_cfg_t;
  typedef struct packed {
    logic curtain_channel_one;
    logic curtain_channel_two;
    logic first_group_sensor_one;
    logic first_group_sensor_two;
    logic second_group_sensor_one;
    logic second_group_sensor_two;
    logic operator_acknowledge_coil;
    logic gate_coil;
    logic override_coil;
  } lcm_in_t;
  typedef struct packed {
    logic safe_enable_contact;
    logic muting_active_contact;
    logic fault_contact;
  } lcm_out_t;
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_PROOF = 6'b000010,
    ST_WAIT_ACK = 6'b000100,
    ST_ENABLED = 6'b001000,
    ST_MUTING = 6'b010000,
    ST_FAULT = 6'b100000
  } lcm_state_t;
endpackage

// ### hdl/lcm_regs.svh
`ifndef LCM_REGS_SVH
`define LCM_REGS_SVH
// ==========================================
// setting encodings
`define LCM_GATE_NONE 1'b0
`define LCM_GATE_EXT 1'b1
`define LCM_RST_AUTO 2'h0
`define LCM_RST_MANUAL 2'h1
`define LCM_RST_SUPV 2'h2
`define LCM_ARR_2P 2'h0
`define LCM_ARR_2S 2'h1
`define LCM_ARR_4P 2'h2
`define LCM_ARR_4S 2'h3
// ==========================================
// time base: one tick per 100 ms, windows in ticks, 0 = off
`define LCM_CLK_HZ 250000000
`define LCM_TICK_MS 100
`define LCM_TICK_CYC ((`LCM_CLK_HZ / 1000) * `LCM_TICK_MS)
`define LCM_WIN_W 13
`define LCM_WIN_OFF 13'h0000
// factory values in ticks: 3.0 s, off, 4.0 s, off
`define LCM_MISMATCH_RST 13'h001E
`define LCM_MUTING_RST 13'h0000
`define LCM_SYNC_RST 13'h0028
`define LCM_RELEASE_RST 13'h0000
`endif

// ### hdl/lcm_tick.sv
`timescale 1ns/1ps
`include "lcm_regs.svh"
module lcm_tick #(
  parameter int TICK_CYC = `LCM_TICK_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // tick pulse
  output logic tick_o
);
  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } lcm_tick_st_t;
  lcm_tick_st_t s_reg;
  lcm_tick_st_t s_next;
  always_comb
  begin
    s_next = s_reg;
    s_next.tick = 1'b0;
    if (s_reg.cnt >= 32'(TICK_CYC - 1))
    begin
      s_next.cnt = 32'h0000_0000;
      s_next.tick = 1'b1;
    end
    else
    begin
      s_next.cnt = s_reg.cnt + 32'h0000_0001;
    end
  end
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end
  assign tick_o = s_reg.tick;
endmodule

// ### hdl/lcm_win.sv
`timescale 1ns/1ps
`include "lcm_regs.svh"
module lcm_win #(
  parameter int W = `LCM_WIN_W
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // control
  input wire logic tick_i,
  input wire logic run_i,
  input wire logic [W-1:0] limit_i,
  // result
  output logic expired_o,
  output logic [W-1:0] elapsed_o
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic expired;
  } lcm_win_st_t;
  lcm_win_st_t s_reg;
  lcm_win_st_t s_next;
  // a window of zero is off: it never expires
  always_comb
  begin
    s_next = s_reg;
    if (!run_i || limit_i == '0)
    begin
      s_next.cnt = '0;
      s_next.expired = 1'b0;
    end
    else if (tick_i && !s_reg.expired)
    begin
      s_next.cnt = s_reg.cnt + W'(1);
      if (s_reg.cnt + W'(1) >= limit_i)
        s_next.expired = 1'b1;
    end
  end
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end
  assign expired_o = s_reg.expired;
  assign elapsed_o = s_reg.cnt;
endmodule

// ### verif/lcm_cmb_asserts.sv
`timescale 1ns/1ps
`include "lcm_regs.svh"
module lcm_cmb_asserts #(
  parameter int TICK_CYC = 10
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // register port
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  // terminals and contacts
  input wire lcm_pkg::lcm_in_t pins_i,
  input wire lcm_pkg::lcm_out_t contacts_o
);
  import lcm_pkg::*;
  // ==========
  // shadow of the settings, taken from writes on the port
  logic gate_reg;
  logic [12:0] mis_reg, mute_reg, sync_reg, rel_reg;
  logic [31:0] mis_cnt, mute_cnt, sync_cnt;
  logic c1, c2, en, mu, flt, gated;
  assign c1 = pins_i.curtain_channel_one;
  assign c2 = pins_i.curtain_channel_two;
  assign en = contacts_o.safe_enable_contact;
  assign mu = contacts_o.muting_active_contact;
  assign flt = contacts_o.fault_contact;
  assign gated = gate_reg && !pins_i.gate_coil;
  // a window may end up to one tick late, plus the input pipeline
  function automatic logic [31:0] lim(input logic [12:0] w);
    return (32'(w) + 32'h0000_0001) * 32'(TICK_CYC) + 32'h0000_0006;
  endfunction
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      gate_reg <= `LCM_GATE_NONE;
      mis_reg <= `LCM_MISMATCH_RST;
      mute_reg <= `LCM_MUTING_RST;
      sync_reg <= `LCM_SYNC_RST;
      rel_reg <= `LCM_RELEASE_RST;
      mis_cnt <= '0;
      mute_cnt <= '0;
      sync_cnt <= '0;
    end
    else
    begin
      if (wr_i && addr_i == 4'h0) gate_reg <= wdata_i[0];
      if (wr_i && addr_i == 4'h1) mis_reg <= wdata_i[12:0];
      if (wr_i && addr_i == 4'h2) mute_reg <= wdata_i[12:0];
      if (wr_i && addr_i == 4'h3) sync_reg <= wdata_i[12:0];
      if (wr_i && addr_i == 4'h4) rel_reg <= wdata_i[12:0];
      // counters run only where the check is armed
      mis_cnt <= (c1 != c2 && !flt && !mu && !gated) ? mis_cnt + 32'h0000_0001 : '0;
      mute_cnt <= (mu && !flt) ? mute_cnt + 32'h0000_0001 : '0;
      sync_cnt <= (pins_i.first_group_sensor_one != pins_i.first_group_sensor_two
                   && (en || mu) && !flt) ? sync_cnt + 32'h0000_0001 : '0;
    end
  end
  // ==========
  // properties
  property p_rd_idle;
    @(posedge clk_i) disable iff (!nrst_i) !rd_i |=> rdata_o == '0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer");
  property p_excl;
    @(posedge clk_i) disable iff (!nrst_i) en |-> !flt;
  endproperty
  a_excl: assert property (p_excl) else $error("enable with fault");
  property p_en_rise;
    @(posedge clk_i) disable iff (!nrst_i) $rose(en) |-> $past(c1 && c2, 3);
  endproperty
  a_en_rise: assert property (p_en_rise) else $error("enable without clear curtain");
  property p_fault_exit;
    @(posedge clk_i) disable iff (!nrst_i) $fell(flt) |-> $past(!c1 && !c2, 3);
  endproperty
  a_fault_exit: assert property (p_fault_exit) else $error("fault left early");
  property p_gate;
    @(posedge clk_i) disable iff (!nrst_i) gated [*4] |-> contacts_o == '0;
  endproperty
  a_gate: assert property (p_gate) else $error("contacts on while gated off");
  property p_mismatch;
    @(posedge clk_i) disable iff (!nrst_i) mis_reg == '0 || mis_cnt < lim(mis_reg);
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("mismatch not flagged");
  property p_sync;
    @(posedge clk_i) disable iff (!nrst_i) sync_reg == '0 || sync_cnt < lim(sync_reg);
  endproperty
  a_sync: assert property (p_sync) else $error("sync loss not flagged");
  property p_mute;
    @(posedge clk_i) disable iff (!nrst_i) mute_reg == '0 || mute_cnt < lim(mute_reg);
  endproperty
  a_mute: assert property (p_mute) else $error("muting overran window");
  property p_no_ovr;
    @(posedge clk_i) disable iff (!nrst_i) rel_reg == '0 && flt |-> !mu;
  endproperty
  a_no_ovr: assert property (p_no_ovr) else $error("bridging with release off");
endmodule
bind lcm_curtain_muting_block lcm_cmb_asserts #(.TICK_CYC(TICK_CYC)) i_lcm_cmb_asserts (
  .clk_i(clk_i),
  .nrst_i(nrst_i),
  .addr_i(addr_i),
  .wdata_i(wdata_i),
  .wr_i(wr_i),
  .rd_i(rd_i),
  .rdata_o(rdata_o),
  .pins_i(pins_i),
  .contacts_o(contacts_o)
);

// ### verif/lcm_far_side.sv
`timescale 1ns/1ps
module lcm_far_side (
  // scene
  input wire logic beam_clear_i,
  input wire logic chan_two_stuck_i,
  input wire logic [3:0] sensors_i,
  input wire logic ack_i,
  input wire logic gate_i,
  input wire logic ovr_i,
  // terminals
  output lcm_pkg::lcm_in_t pins_o
);
  import lcm_pkg::*;
  // every coil is a bare wire from its sensor; only curtain channel two is gated, by chan_two_stuck_i
  assign pins_o = '{beam_clear_i, beam_clear_i && !chan_two_stuck_i,
                    sensors_i[0], sensors_i[1], sensors_i[2], sensors_i[3],
                    ack_i, gate_i, ovr_i};
endmodule

// ### verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import lcm_pkg::*;
  logic clk_i, nrst_i, wr_i, rd_i, beam, stuck, ack, gate, ovr;
  logic [3:0] addr_i, sens;
  logic [31:0] wdata_i, rdata_o;
  logic [2:0] outs;
  lcm_in_t pins;
  lcm_out_t contacts_o;
  int err_count, checked;
  assign outs = contacts_o;
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  lcm_curtain_muting_block #(.TICK_CYC(10)) i_lcm_curtain_muting_block (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .pins_i(pins),
    .contacts_o(contacts_o)
  );
  lcm_far_side i_lcm_far_side (
    .beam_clear_i(beam),
    .chan_two_stuck_i(stuck),
    .sensors_i(sens),
    .ack_i(ack),
    .gate_i(gate),
    .ovr_i(ovr),
    .pins_o(pins)
  );
  // ==========
  // tasks
  task automatic report_and_stop;
    $display("compared %0d, mismatched %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: %s got %h", $time, what, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'h1;
    @(posedge clk_i);
    wr_i <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'h1;
    @(posedge clk_i);
    rd_i <= 1'h0;
    #1;
    chk(rdata_o & m, e, "read");
    @(posedge clk_i);
  endtask
  // bounded wait; running out of patience ends the run
  // outputs are looked at 1 ns after an edge; the task returns on an edge so that
  // the next stimulus lands there by non-blocking assignment
  task automatic wait_out(input logic [2:0] e, input logic [2:0] m, input int n, string w);
    int i;
    #1;
    for (i = 0; i < n && (outs & m) !== e; i++)
    begin
      @(posedge clk_i);
      #1;
    end
    chk({29'h0000_0000, outs & m}, {29'h0000_0000, e}, w);
    @(posedge clk_i);
    if (i >= n) report_and_stop();
  endtask
  task automatic hold_out(input logic [2:0] e, input int n, input string w);
    int i;
    #1;
    for (i = 0; i < n && outs === e; i++)
    begin
      @(posedge clk_i);
      #1;
    end
    chk({29'h0000_0000, outs}, {29'h0000_0000, e}, w);
    @(posedge clk_i);
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    $display("mismatch at %0t: run hung", $time);
    report_and_stop();
  end
  // ==========
  // tests
  initial
  begin
    {err_count, checked} = '0;
    {nrst_i, wr_i, rd_i, beam, stuck, ack, gate, ovr} = '0;
    {addr_i, sens, wdata_i} = '0;
    repeat (20) @(posedge clk_i);
    nrst_i <= 1'h1;
    rd(4'h0, 32'h0000_003F, 32'h0000_0002);
    rd(4'h1, 32'h0000_1FFF, 32'h0000_001E);
    rd(4'h2, 32'h0000_1FFF, 32'h0000_0000);
    rd(4'h3, 32'h0000_1FFF, 32'h0000_0028);
    rd(4'h4, 32'h0000_1FFF, 32'h0000_0000);
    rd(4'h6, 32'hFFFF_FFFF, 32'h0000_0000);
    wr(4'h1, 32'h0000_0002);
    rd(4'h1, 32'h0000_1FFF, 32'h0000_0002);
    wr(4'h0, 32'h0000_0006);
    rd(4'h0, 32'h0000_003F, 32'h0000_0002);
    $display("test defaults ended");
    beam <= 1'h1;
    hold_out(3'h0, 12, "manual without ack");
    ack <= 1'h1;
    wait_out(3'h4, 3'h7, 10, "manual ack");
    ack <= 1'h0;
    beam <= 1'h0;
    wait_out(3'h0, 3'h7, 10, "curtain broken");
    stuck <= 1'h1;
    beam <= 1'h1;
    hold_out(3'h0, 12, "mismatch early");
    wait_out(3'h1, 3'h7, 40, "mismatch fault");
    rd(4'h5, 32'h0000_07FF, 32'h0000_0101);
    rd(4'h1, 32'h1FFF_1FFF, 32'h0002_0002);
    beam <= 1'h0;
    stuck <= 1'h0;
    wait_out(3'h0, 3'h7, 10, "fault cleared");
    $display("test mismatch ended");
    wr(4'h0, 32'h0000_0000);
    wr(4'h2, 32'h0000_0002);
    beam <= 1'h1;
    wait_out(3'h4, 3'h7, 6, "auto restart");
    sens <= 4'h3;
    beam <= 1'h0;
    wait_out(3'h2, 3'h3, 10, "muting on");
    wait_out(3'h1, 3'h3, 40, "muting overrun");
    sens <= 4'h0;
    wait_out(3'h0, 3'h7, 10, "fault cleared");
    beam <= 1'h1;
    wait_out(3'h4, 3'h7, 6, "auto again");
    $display("test muting ended");
    wr(4'h3, 32'h0000_0002);
    sens <= 4'h1;
    wait_out(3'h1, 3'h5, 40, "sync fault");
    sens <= 4'h0;
    beam <= 1'h0;
    wait_out(3'h0, 3'h7, 10, "fault cleared");
    wr(4'h0, 32'h0000_0004);
    beam <= 1'h1;
    hold_out(3'h0, 12, "supervised idle");
    ack <= 1'h1;
    hold_out(3'h0, 6, "supervised ack held");
    ack <= 1'h0;
    wait_out(3'h4, 3'h7, 10, "supervised release");
    $display("test sync and restart ended");
    wr(4'h0, 32'h0000_0001);
    wait_out(3'h0, 3'h7, 10, "gated off");
    gate <= 1'h1;
    wait_out(3'h4, 3'h7, 10, "gated on");
    sens <= 4'h1;
    wait_out(3'h1, 3'h7, 40, "sync fault");
    ovr <= 1'h1;
    hold_out(3'h1, 12, "no override");
    ovr <= 1'h0;
    wr(4'h4, 32'h0000_0002);
    ovr <= 1'h1;
    wait_out(3'h3, 3'h7, 10, "override bridging");
    wait_out(3'h1, 3'h7, 40, "override expired");
    ovr <= 1'h0;
    sens <= 4'h0;
    beam <= 1'h0;
    wait_out(3'h0, 3'h7, 10, "override cleanup");
    $display("test gate and override ended");
    beam <= 1'h1;
    wr(4'h0, 32'h0000_001A);
    rd(4'h0, 32'h0000_003F, 32'h0000_001A);
    ack <= 1'h1;
    hold_out(3'h0, 6, "proof ack without break");
    ack <= 1'h0;
    hold_out(3'h0, 8, "proof needs break");
    beam <= 1'h0;
    hold_out(3'h0, 6, "proof break");
    beam <= 1'h1;
    ack <= 1'h1;
    hold_out(3'h0, 6, "proof ack held");
    ack <= 1'h0;
    wait_out(3'h4, 3'h7, 10, "proof release");
    $display("test proof ended");
    sens <= 4'hC;
    hold_out(3'h4, 8, "group b ignored");
    wr(4'h0, 32'h0000_0022);
    wait_out(3'h2, 3'h3, 10, "group b muting");
    sens <= 4'h0;
    wait_out(3'h4, 3'h7, 10, "group b muting end");
    $display("test sensor groups ended");
    report_and_stop();
  end
endmodule
